/* verilog/ofs_top.v */
// output terminal function selector with apb parameter registers
// register map, one 32-bit word each, low 16 bits used:
//   0x00 mode of the multiplexed terminal
//   0x04 switch-mode function code
//   0x08 base relay function code
//   0x0C extension relay function code
//   0x10 first open-collector function code
//   0x14 extension digital output function code
//   0x18 terminal status, read only
//   0x1C pulse half period in clock cycles, zero stops the train
//   0x20 condition status, read only, bit k is the code k condition
//
// limitations: analog output, pulse scaling and codes above 14 are not
// built here; every condition input must come from this clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ofs_defines.vh"

module ofs_top #(
    parameter integer ADDR_W        = 8,
    parameter integer PLC_PULSE_CYC = `OFS_PLC_PULSE_CYC
) (
    input  wire              CORE_CLK,
    input  wire              SYS_RST,
    // apb slave
    // zero wait states; the master runs on this clock as well
    input  wire              PSEL,
    input  wire              PENABLE,
    input  wire              PWRITE,
    input  wire [ADDR_W-1:0] PADDR,
    input  wire [31:0]       PWDATA,
    output wire [31:0]       PRDATA,
    output wire              PREADY,
    output wire              PSLVERR,
    // drive conditions from other units, same clock
    // levels, except the one-cycle program-cycle done strobe
    input  wire              DRIVE_RUNNING,
    input  wire              FAULT_STOPPED,
    input  wire              FREQ_LEVEL_DETECT_ONE,
    input  wire              FREQ_REACHED,
    input  wire              OUTPUT_FREQ_ZERO,
    input  wire              MOTOR_OVERLOAD_WARN,
    input  wire              DRIVE_OVERLOAD_WARN,
    input  wire              SET_COUNT_REACHED,
    input  wire              DESIGNATED_COUNT_REACHED,
    input  wire              LENGTH_EXCEEDED,
    input  wire              PROGRAM_CYCLE_DONE,
    input  wire              RUN_TIME_EXCEEDED,
    input  wire              SET_FREQ_BEYOND_LIMIT,
    input  wire              OUTPUT_FREQ_AT_LIMIT,
    input  wire              SPEED_CONTROL_MODE,
    input  wire              TORQUE_AT_LIMIT,
    input  wire              STALL_PROTECTION,
    // terminals
    // all active high: 1 closes the relay or turns the switch on
    output wire              MULTIPLEXED_OUTPUT_TERMINAL,
    output wire              BASE_RELAY_OUT,
    output wire              EXTENSION_RELAY_OUT,
    output wire              FIRST_OPEN_COLLECTOR_OUTPUT,
    output wire              EXTENSION_DIGITAL_OUT
);

    // five terminals share one code table; the stretcher counter holds
    // 250 ms at 40 MHz, a much faster clock needs PLC_W widened
    localparam integer NUM_TERM = 5;
    localparam integer PLC_W    = 24;

    // half period floor cut to counter width on purpose, so the compare
    // stays 16 bits and the selected value fits half_eff
    localparam integer HALF_MIN_I = `OFS_PULSE_HALF_MIN;
    localparam [15:0]  HALF_MIN   = HALF_MIN_I[15:0];

    // parameter registers
    // func_r packs the five code registers, 16 bits per terminal in
    // terminal order: switch, base relay, ext relay, first oc, ext out
    reg  [15:0]         mode_r;
    reg  [15:0]         pulse_half_r;
    reg  [16*NUM_TERM-1:0] func_r;
    reg  [NUM_TERM-1:0] term_r;
    reg                 mux_pin_r;
    reg  [31:0]         prdata_r;

    // pulse generator and program-cycle stretcher
    // both run free of the bus; the pulse settings come from registers, the stretch width from PLC_PULSE_CYC
    reg  [15:0]         pulse_cnt_r;
    reg  [15:0]         pulse_cnt_nxt;
    reg                 pulse_r;
    reg                 pulse_nxt;
    reg  [PLC_W-1:0]    plc_cnt_r;

    // decode, selection and pulse helper nets
    wire                wr_en;
    wire                rd_setup;
    wire                addr_ok;
    wire                plc_pulse;
    wire [15:0]         cond;
    wire [15:0]         half_eff;
    wire                pulse_mode;
    reg  [31:0]         rd_mux;
    wire [NUM_TERM-1:0] term_nxt;

    // conditions indexed by function code; index 0 and unused stay low
    // every input here is a level made by another unit on this clock,
    // so no synchroniser sits in front of it; a code that needs two
    // or more facts (5, 13, 14) ands them here, so the selector stays a plain
    // one-of-sixteen pick
    assign plc_pulse = (plc_cnt_r != {PLC_W{1'b0}});
    assign cond[0]  = 1'b0;
    assign cond[1]  = DRIVE_RUNNING;
    assign cond[2]  = FAULT_STOPPED;
    assign cond[3]  = FREQ_LEVEL_DETECT_ONE;
    assign cond[4]  = FREQ_REACHED;
    assign cond[5]  = DRIVE_RUNNING & OUTPUT_FREQ_ZERO;
    assign cond[6]  = MOTOR_OVERLOAD_WARN;
    assign cond[7]  = DRIVE_OVERLOAD_WARN;
    assign cond[8]  = SET_COUNT_REACHED;
    assign cond[9]  = DESIGNATED_COUNT_REACHED;
    assign cond[10] = LENGTH_EXCEEDED;
    // code 11 reads the stretched pulse, not the raw done strobe
    assign cond[11] = plc_pulse;
    assign cond[12] = RUN_TIME_EXCEEDED;
    // multi-fact codes: every fact must hold in the same cycle
    assign cond[13] = SET_FREQ_BEYOND_LIMIT
                    & OUTPUT_FREQ_AT_LIMIT;
    assign cond[14] = SPEED_CONTROL_MODE & TORQUE_AT_LIMIT
                    & STALL_PROTECTION;
    assign cond[15] = 1'b0;

    // picks the condition for a code; anything above the top code is off
    // the whole 16-bit code is compared, so a value such as 0x0011
    // cannot alias code 1 through its low nibble
    function sel_cond;
        input [15:0] code;
        input [15:0] conds;
        begin
            if (code > `OFS_CODE_MAX) begin
                sel_cond = 1'b0;
            end else begin
                sel_cond = conds[code[3:0]];
            end
        end
    endfunction

    // apb decode: zero wait states, so access phase always completes
    // a transfer is a setup cycle then one access cycle; writes land at
    // the edge that closes the access cycle, reads were captured at the
    // edge that closed setup; an unmapped address raises the error
    // response in the access cycle and changes nothing
    assign wr_en    = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign addr_ok  = (PADDR == `OFS_ADDR_MODE)
                    | (PADDR == `OFS_ADDR_SWITCH_FUNC)
                    | (PADDR == `OFS_ADDR_BASE_RELAY)
                    | (PADDR == `OFS_ADDR_EXT_RELAY)
                    | (PADDR == `OFS_ADDR_FIRST_OC)
                    | (PADDR == `OFS_ADDR_EXT_DIGITAL)
                    | (PADDR == `OFS_ADDR_TERM_STATUS)
                    | (PADDR == `OFS_ADDR_PULSE_HALF)
                    | (PADDR == `OFS_ADDR_COND_STATUS);
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL & PENABLE & ~addr_ok;
    assign PRDATA   = prdata_r;

    // read mux; narrow registers sit in the low bits, the rest reads zero
    // status word: bits 4:0 the terminal flops (0 is the switch-mode
    // result, kept even while the pin shows pulses), bit 5 the shared
    // pin, bit 6 set while the pin is in pulse mode; bits above 6 read
    // zero
    always @* begin
        rd_mux = 32'h00000000;
        case (PADDR)
            `OFS_ADDR_MODE:        rd_mux[15:0] = mode_r;
            `OFS_ADDR_SWITCH_FUNC: rd_mux[15:0] = func_r[15:0];
            `OFS_ADDR_BASE_RELAY:  rd_mux[15:0] = func_r[31:16];
            `OFS_ADDR_EXT_RELAY:   rd_mux[15:0] = func_r[47:32];
            `OFS_ADDR_FIRST_OC:    rd_mux[15:0] = func_r[63:48];
            `OFS_ADDR_EXT_DIGITAL: rd_mux[15:0] = func_r[79:64];
            `OFS_ADDR_TERM_STATUS: begin
                rd_mux[NUM_TERM-1:0]           = term_r;
                rd_mux[`OFS_STAT_MUX_PIN]     = mux_pin_r;
                rd_mux[`OFS_STAT_PULSE_MODE]  = pulse_mode;
            end
            `OFS_ADDR_PULSE_HALF:  rd_mux[15:0] = pulse_half_r;
            `OFS_ADDR_COND_STATUS: rd_mux[15:0] = cond;
            default:               rd_mux = 32'h00000000;
        endcase
    end

    // read data is captured in setup so it stands through the access phase
    // limitation: a status read shows the state one cycle before the
    // access cycle, never the value of the closing edge itself
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            prdata_r <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_r <= rd_mux;
        end
    end

    // parameter register writes; an unmapped write is dropped
    // the status words are read only and a write to them is dropped
    // without error; code registers keep any 16-bit value, and an unused
    // code simply selects nothing
    // reset loads the factory codes: fault on the base relay, running on
    // the first open-collector output, frequency reached on the ext output
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mode_r       <= `OFS_RST_MODE;
            func_r[15:0] <= `OFS_RST_SWITCH_FUNC;
            func_r[31:16] <= `OFS_RST_BASE_RELAY;
            func_r[47:32] <= `OFS_RST_EXT_RELAY;
            func_r[63:48] <= `OFS_RST_FIRST_OC;
            func_r[79:64] <= `OFS_RST_EXT_DIGITAL;
            pulse_half_r <= `OFS_RST_PULSE_HALF;
        end else if (wr_en) begin
            case (PADDR)
                `OFS_ADDR_MODE:        mode_r <= PWDATA[15:0];
                `OFS_ADDR_SWITCH_FUNC: func_r[15:0] <= PWDATA[15:0];
                `OFS_ADDR_BASE_RELAY:  func_r[31:16] <= PWDATA[15:0];
                `OFS_ADDR_EXT_RELAY:   func_r[47:32] <= PWDATA[15:0];
                `OFS_ADDR_FIRST_OC:    func_r[63:48] <= PWDATA[15:0];
                `OFS_ADDR_EXT_DIGITAL: func_r[79:64] <= PWDATA[15:0];
                `OFS_ADDR_PULSE_HALF:  pulse_half_r <= PWDATA[15:0];
                default:               mode_r <= mode_r;
            endcase
        end
    end

    // next value of each terminal, one selector per terminal; all five
    // read the same condition vector, so one code table serves them
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERM; gi = gi + 1) begin : g_term
            assign term_nxt[gi] = sel_cond(func_r[16*gi+15:16*gi],
                                           cond);
        end
    endgenerate

    // one flop per terminal keeps a code change glitch-free: the pin
    // moves only on the clock, never while a selector settles
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            term_r <= {NUM_TERM{1'b0}};
        end else begin
            term_r <= term_nxt;
        end
    end

    // program-cycle stretcher; a new cycle end restarts the full width
    // two cycle ends closer than the pulse width merge into one longer
    // pulse: the counter reloads rather than queueing a second pulse;
    // the terminal is high while the count is nonzero
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            plc_cnt_r <= {PLC_W{1'b0}};
        end else if (PROGRAM_CYCLE_DONE) begin
            plc_cnt_r <= PLC_PULSE_CYC[PLC_W-1:0];
        end else if (plc_pulse) begin
            plc_cnt_r <= plc_cnt_r - {{(PLC_W-1){1'b0}}, 1'b1};
        end
    end

    // half periods below the floor are raised so the rate never
    // passes the top pulse frequency; zero stops the train low
    // at 40 MHz the floor is 200 cycles, a half period of 5 us
    assign pulse_mode = (mode_r == `OFS_MODE_PULSE);
    assign half_eff   = (pulse_half_r < HALF_MIN)
                      ? HALF_MIN : pulse_half_r;

    // square wave counter for the fast pulse output
    // the pin toggles each time the count reaches half_eff - 1, so a period
    // is twice half_eff; leaving pulse mode clears the count so
    // a return starts with a full low half period
    always @* begin
        pulse_cnt_nxt = pulse_cnt_r;
        pulse_nxt     = pulse_r;
        if (!pulse_mode || pulse_half_r == 16'h0000) begin
            pulse_cnt_nxt = 16'h0000;
            pulse_nxt     = 1'b0;
        end else if (pulse_cnt_r >= half_eff - 16'h0001) begin
            pulse_cnt_nxt = 16'h0000;
            pulse_nxt     = ~pulse_r;
        end else begin
            pulse_cnt_nxt = pulse_cnt_r + 16'h0001;
        end
    end

    // counter and level flops of the pulse train; the shared pin is fed
    // from pulse_nxt so it shows the same level as pulse_r
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pulse_cnt_r <= 16'h0000;
            pulse_r     <= 1'b0;
        end else begin
            pulse_cnt_r <= pulse_cnt_nxt;
            pulse_r     <= pulse_nxt;
        end
    end

    // the shared pin shows pulses in mode 0 and the switch terminal in
    // mode 1; other mode values hold it off
    // a mode change takes effect at the next edge; a pulse in flight is
    // cut short, which loads on the pin must tolerate
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mux_pin_r <= 1'b0;
        end else if (pulse_mode) begin
            mux_pin_r <= pulse_nxt;
        end else if (mode_r == `OFS_MODE_SWITCH) begin
            mux_pin_r <= sel_cond(func_r[15:0], cond);
        end else begin
            mux_pin_r <= 1'b0;
        end
    end

    // terminal flop 0 is the switch-mode result and shows only in the status
    // word, the pin takes its own copy in mux_pin_r; flops 1 to 4 drive their terminals directly;
    // nothing here is tri-stated, the switching stages sit outside
    assign MULTIPLEXED_OUTPUT_TERMINAL = mux_pin_r;
    assign BASE_RELAY_OUT              = term_r[1];
    assign EXTENSION_RELAY_OUT         = term_r[2];
    assign FIRST_OPEN_COLLECTOR_OUTPUT = term_r[3];
    assign EXTENSION_DIGITAL_OUT       = term_r[4];

endmodule
`default_nettype wire

/* common/ofs_defines.vh */
// register offsets, reset values and timing figures of the output selector
`ifndef OFS_DEFINES_VH
`define OFS_DEFINES_VH

// register byte offsets, one aligned 32-bit word each
`define OFS_ADDR_MODE          8'h00
`define OFS_ADDR_SWITCH_FUNC   8'h04
`define OFS_ADDR_BASE_RELAY    8'h08
`define OFS_ADDR_EXT_RELAY     8'h0C
`define OFS_ADDR_FIRST_OC      8'h10
`define OFS_ADDR_EXT_DIGITAL   8'h14
`define OFS_ADDR_TERM_STATUS   8'h18
`define OFS_ADDR_PULSE_HALF    8'h1C
`define OFS_ADDR_COND_STATUS   8'h20

// reset values of the parameter registers
`define OFS_RST_MODE           16'h0000
`define OFS_RST_SWITCH_FUNC    16'h0000
`define OFS_RST_BASE_RELAY     16'h0002
`define OFS_RST_EXT_RELAY      16'h0000
`define OFS_RST_FIRST_OC       16'h0001
`define OFS_RST_EXT_DIGITAL    16'h0004
`define OFS_RST_PULSE_HALF     16'h0000

// mode values of the multiplexed output terminal
`define OFS_MODE_PULSE         16'h0000
`define OFS_MODE_SWITCH        16'h0001

// highest implemented function code
`define OFS_CODE_MAX           16'h000E

// field positions in the terminal status word
`define OFS_STAT_MUX_PIN       5
`define OFS_STAT_PULSE_MODE    6

// timing figures
`define OFS_CLK_HZ             40000000
`define OFS_PULSE_MAX_HZ       100000
`define OFS_PLC_PULSE_MS       250
`define OFS_PULSE_HALF_MIN     (`OFS_CLK_HZ / (2 * `OFS_PULSE_MAX_HZ))
`define OFS_PLC_PULSE_CYC      ((`OFS_CLK_HZ / 1000) * `OFS_PLC_PULSE_MS)

`endif

/* bench/ofs_top_props.sv */
// port-level assertion checker for the output terminal selector
`timescale 1ns/1ps
`default_nettype none
`include "ofs_defines.vh"
module ofs_props (
    input wire logic        CORE_CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        DRIVE_RUNNING,
    input wire logic        FAULT_STOPPED,
    input wire logic        BASE_RELAY_OUT,
    input wire logic        EXTENSION_RELAY_OUT,
    input wire logic        FIRST_OPEN_COLLECTOR_OUTPUT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    logic [15:0] base_r;
    logic [15:0] oc_r;
    logic [15:0] extr_r;
    wire         wr = PSEL && PENABLE && PWRITE;
    // shadow codes so the checker knows which condition the base relay, ext relay and first oc pins follow
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            base_r <= `OFS_RST_BASE_RELAY;
            oc_r <= `OFS_RST_FIRST_OC;
            extr_r <= `OFS_RST_EXT_RELAY;
        end else if (wr) begin
            if (PADDR == `OFS_ADDR_BASE_RELAY) base_r <= PWDATA[15:0];
            if (PADDR == `OFS_ADDR_FIRST_OC) oc_r <= PWDATA[15:0];
            if (PADDR == `OFS_ADDR_EXT_RELAY) extr_r <= PWDATA[15:0];
        end
    end
    ready_high_a: assert property (PREADY) else $error("pready low");
    err_unmapped_a: assert property (PSEL && PENABLE && PADDR > 8'h20
        |-> PSLVERR) else $error("no error on unmapped address");
    err_mapped_a: assert property (PSEL && PENABLE && PADDR <= 8'h20 &&
        PADDR[1:0] == 2'h0 |-> !PSLVERR) else $error("error on register");
    err_idle_a: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
        else $error("error outside access phase");
    fault_relay_a: assert property (base_r == 16'h2 && FAULT_STOPPED
        |=> BASE_RELAY_OUT) else $error("fault not on relay");
    dead_relay_a: assert property ((base_r == 16'h0 || base_r > 16'hE)
        |=> !BASE_RELAY_OUT) else $error("unused relay driven");
    run_oc_a: assert property (oc_r == 16'h1 |=>
        FIRST_OPEN_COLLECTOR_OUTPUT == $past(DRIVE_RUNNING))
        else $error("running output wrong");
    stop_zero_a: assert property (extr_r == 16'h5 && !DRIVE_RUNNING
        |=> !EXTENSION_RELAY_OUT) else $error("zero speed on at stop");
    reset_clear_a: assert property ($fell(SYS_RST) |->
        !(BASE_RELAY_OUT || EXTENSION_RELAY_OUT))
        else $error("pin on after reset");
endmodule
bind ofs_top ofs_props ofs_props_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DRIVE_RUNNING(DRIVE_RUNNING), .FAULT_STOPPED(FAULT_STOPPED),
    .BASE_RELAY_OUT(BASE_RELAY_OUT),
    .EXTENSION_RELAY_OUT(EXTENSION_RELAY_OUT),
    .FIRST_OPEN_COLLECTOR_OUTPUT(FIRST_OPEN_COLLECTOR_OUTPUT));
`default_nettype wire

/* bench/ofs_load.sv */
// relay coil and open-collector load model on the terminal side
`timescale 1ns/1ps
`default_nettype none
module ofs_load (
    input wire logic [4:0] term_in,
    output logic [4:0]     energized
);
    // contacts treated as ideal: bounce would only blur the bench timing
    assign energized = term_in;
endmodule
`default_nettype wire

/* bench/ofs_top_bench.sv */
// self-checking bench for the output terminal function selector
`timescale 1ns/1ps
`default_nettype none
`include "ofs_defines.vh"
module ofs_top_bench;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic [7:0]  pa = 8'h0;
    logic [31:0] pwd = 32'h0;
    logic [16:0] cond = 17'h0;
    wire  [31:0] prd;
    wire         prdy;
    wire         perr;
    wire  [4:0]  term;
    wire  [4:0]  load;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          compares = 0;
    logic [16:0] mask [0:14] = '{17'h0, 17'h11, 17'h2, 17'h4, 17'h8, 17'h11,
        17'h20, 17'h40, 17'h80, 17'h100, 17'h200, 17'h400, 17'h800,
        17'h3000, 17'h1C000};
    always #12.5 clk = ~clk;
    ofs_top #(.PLC_PULSE_CYC(20)) ofs_top_i (.CORE_CLK(clk), .SYS_RST(rst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
        .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .DRIVE_RUNNING(cond[0]), .FAULT_STOPPED(cond[1]),
        .FREQ_LEVEL_DETECT_ONE(cond[2]), .FREQ_REACHED(cond[3]),
        .OUTPUT_FREQ_ZERO(cond[4]), .MOTOR_OVERLOAD_WARN(cond[5]),
        .DRIVE_OVERLOAD_WARN(cond[6]), .SET_COUNT_REACHED(cond[7]),
        .DESIGNATED_COUNT_REACHED(cond[8]), .LENGTH_EXCEEDED(cond[9]),
        .PROGRAM_CYCLE_DONE(cond[10]), .RUN_TIME_EXCEEDED(cond[11]),
        .SET_FREQ_BEYOND_LIMIT(cond[12]), .OUTPUT_FREQ_AT_LIMIT(cond[13]),
        .SPEED_CONTROL_MODE(cond[14]), .TORQUE_AT_LIMIT(cond[15]),
        .STALL_PROTECTION(cond[16]), .MULTIPLEXED_OUTPUT_TERMINAL(term[0]),
        .BASE_RELAY_OUT(term[1]), .EXTENSION_RELAY_OUT(term[2]),
        .FIRST_OPEN_COLLECTOR_OUTPUT(term[3]), .EXTENSION_DIGITAL_OUT(term[4]));
    ofs_load ofs_load_i (.term_in(term), .energized(load));
    task check(input logic [31:0] seen, input logic [31:0] exp, string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen,
                exp);
        end
    endtask
    // one apb transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'h1);
        rd = prd;
        err = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task setc(input logic [16:0] v);
        @(posedge clk);
        cond <= v;
        @(posedge clk);
        #1;
    endtask
    task t_reset;
        logic [15:0] rv [0:5];
        rv = '{16'h0, 16'h0, 16'h2, 16'h0, 16'h1, 16'h4};
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            check(rd, {16'h0, rv[i]}, "reset value");
        end
        apb(1'h0, 8'h40, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        check(32'(load), 32'h0, "pins idle");
        setc(17'h2);
        check(32'(load[1]), 32'h1, "fault relay");
        setc(17'h0);
        $display("test reset done");
    endtask
    // every code but 11 on one pin: its condition turns it on, part of it does not
    task t_codes;
        apb(1'h1, `OFS_ADDR_BASE_RELAY, 32'h0);
        apb(1'h1, `OFS_ADDR_EXT_RELAY, 32'h5);
        for (int c = 0; c < 17; c++) begin
            if (c == 11) continue;
            apb(1'h1, `OFS_ADDR_EXT_DIGITAL, (c == 16) ? 32'h20 : 32'(c));
            setc((c == 0 || c > 14) ? 17'h1FFFF : mask[c]);
            check(32'(load[4]), 32'(c > 0 && c < 15), "code on");
            if (c > 0 && c < 15) begin
                setc(mask[c] & (mask[c] - 17'h1));
                check(32'(load[4]), 32'h0, "partial");
            end
            setc(17'h0);
        end
        $display("test codes done");
    endtask
    task t_terms;
        logic [16:0] cb [0:4];
        cb = '{17'h2, 17'h1, 17'h20, 17'h80, 17'h800};
        apb(1'h1, `OFS_ADDR_MODE, 32'h1);
        apb(1'h1, `OFS_ADDR_SWITCH_FUNC, 32'h2);
        apb(1'h1, `OFS_ADDR_BASE_RELAY, 32'h1);
        apb(1'h1, `OFS_ADDR_EXT_RELAY, 32'h6);
        apb(1'h1, `OFS_ADDR_FIRST_OC, 32'h8);
        apb(1'h1, `OFS_ADDR_EXT_DIGITAL, 32'hC);
        for (int j = 0; j < 5; j++) begin
            setc(cb[j]);
            check(32'(load), 32'h1 << j, "own code per pin");
        end
        apb(1'h0, `OFS_ADDR_TERM_STATUS, 32'h0);
        check(rd, 32'h10, "terminal status");
        apb(1'h0, `OFS_ADDR_COND_STATUS, 32'h0);
        check(rd, 32'h1000, "condition status");
        setc(17'h0);
        $display("test terms done");
    endtask
    task t_plc;
        int n;
        n = 0;
        apb(1'h1, `OFS_ADDR_BASE_RELAY, 32'hB);
        @(posedge clk);
        cond <= 17'h400;
        @(posedge clk);
        cond <= 17'h0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (load[1] === 1'h1) n++;
        end
        check(n, 20, "cycle pulse width");
        $display("test plc done");
    endtask
    // half period below the floor must be raised to the 100 kHz limit
    task t_pulse;
        int n;
        n = 0;
        apb(1'h1, `OFS_ADDR_PULSE_HALF, 32'hA);
        apb(1'h1, `OFS_ADDR_MODE, 32'h0);
        while (load[0] !== 1'h0 && n < 900) begin
            @(posedge clk);
            #1;
            n++;
        end
        while (load[0] !== 1'h1 && n < 900) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        while (load[0] === 1'h1 && n < 900) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n, `OFS_PULSE_HALF_MIN, "pulse half period");
        apb(1'h1, `OFS_ADDR_MODE, 32'h2);
        setc(17'h2);
        check(32'(load[0]), 32'h0, "unused mode off");
        $display("test pulse done");
    endtask
    task test_done;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog sized well beyond the under one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        t_reset;
        t_codes;
        t_terms;
        t_plc;
        t_pulse;
        test_done;
    end
endmodule
`default_nettype wire
